// *** hw/pdb_pkg.sv ***
// Constants and types for the port drive boost and line swap register bank
package pdb_pkg;

   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int NUM_PORTS = 8;
   localparam int BOOST_W   = 2;
   localparam int BOOST_ALL = NUM_PORTS * BOOST_W;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_UP_BOOST = 8'hF6;
   localparam logic [7:0] ADDR_HI_BOOST = 8'hF7;
   localparam logic [7:0] ADDR_LO_BOOST = 8'hF8;
   localparam logic [7:0] ADDR_SWAP     = 8'hFA;

   // ----------------------------------------
   // Field layouts and reset values
   // ----------------------------------------
   localparam int UP_BOOST_MSB = 1;
   localparam int HI_BOOST_MSB = 5;
   localparam int P7_LSB       = 4;
   localparam int P6_LSB       = 2;
   localparam int P5_LSB       = 0;
   localparam int P4_LSB       = 6;
   localparam int P3_LSB       = 4;
   localparam int P2_LSB       = 2;
   localparam int P1_LSB       = 0;
   localparam int UP_PORT      = 0;
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // ----------------------------------------
   // Boost codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      PDB_BOOST_NONE = 2'h0,
      PDB_BOOST_LOW  = 2'h1,
      PDB_BOOST_MED  = 2'h2,
      PDB_BOOST_HIGH = 2'h3
   } pdb_boost_t;

endpackage : pdb_pkg

// *** hw/pdb_regs.sv ***
// Port drive boost and line pair swap configuration register bank
//
// Operation
// - Upstream boost level is bits 1:0 of upstream boost register, passed unchanged.
// - Boost code: 0 none, 1 low ~4%, 2 medium ~8%, 3 high ~12%.
// - Ports 7, 6, 5 boost from high register bits 5:4, 3:2, 1:0.
// - Ports 4, 3, 2, 1 boost from low register bits 7:6, 5:4, 3:2, 1:0.
// - Swap clear: D+ on positive pin, D- on negative; set exchanges them.
// - Swap register bits 7..1 control downstream ports; bit 0 the upstream port.
`timescale 1ns/1ps

module pdb_regs
   import pdb_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   input  wire logic [7:0]           cfg_addr,
   input  wire logic [7:0]           cfg_wdata,
   input  wire logic                 cfg_wr,
   input  wire logic                 cfg_rd,
   output logic      [7:0]           cfg_rdata,
   output logic      [BOOST_W-1:0]   upstream_boost_level,
   output logic      [BOOST_W-1:0]   port1_boost_level,
   output logic      [BOOST_W-1:0]   port2_boost_level,
   output logic      [BOOST_W-1:0]   port3_boost_level,
   output logic      [BOOST_W-1:0]   port4_boost_level,
   output logic      [BOOST_W-1:0]   port5_boost_level,
   output logic      [BOOST_W-1:0]   port6_boost_level,
   output logic      [BOOST_W-1:0]   port7_boost_level,
   output logic      [NUM_PORTS-1:0] boost_step_low,
   output logic      [NUM_PORTS-1:0] boost_step_med,
   output logic      [NUM_PORTS-1:0] boost_step_high,
   output logic      [NUM_PORTS-1:0] line_pair_swap_bits,
   input  wire logic [NUM_PORTS-1:0] tx_dplus,
   input  wire logic [NUM_PORTS-1:0] tx_dminus,
   output logic      [NUM_PORTS-1:0] positive_line_pin,
   output logic      [NUM_PORTS-1:0] negative_line_pin,
   input  wire logic [NUM_PORTS-1:0] positive_line_in,
   input  wire logic [NUM_PORTS-1:0] negative_line_in,
   output logic      [NUM_PORTS-1:0] rx_dplus,
   output logic      [NUM_PORTS-1:0] rx_dminus
);

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   // Reserved bits are not stored at all, so they cannot be written
   logic [UP_BOOST_MSB:0]  upstream_drive_boost;
   logic [HI_BOOST_MSB:0]  high_ports_drive_boost;
   logic [7:0]             low_ports_drive_boost;
   logic [NUM_PORTS-1:0]   line_pair_swap;
   logic [BOOST_ALL-1:0]   boost_vec;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire logic       wr_up   = cfg_wr && (cfg_addr == ADDR_UP_BOOST);
   wire logic       wr_hi   = cfg_wr && (cfg_addr == ADDR_HI_BOOST);
   wire logic       wr_lo   = cfg_wr && (cfg_addr == ADDR_LO_BOOST);
   wire logic       wr_swap = cfg_wr && (cfg_addr == ADDR_SWAP);
   wire logic [7:0] next_rdata;

   // Unmapped offsets read as zero
   assign next_rdata =
      (cfg_addr == ADDR_UP_BOOST) ? {6'h00, upstream_drive_boost}   :
      (cfg_addr == ADDR_HI_BOOST) ? {2'h0, high_ports_drive_boost}  :
      (cfg_addr == ADDR_LO_BOOST) ? low_ports_drive_boost           :
      (cfg_addr == ADDR_SWAP)     ? line_pair_swap                  :
      READ_ZERO;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Zero at reset keeps every port compliant until configured
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         upstream_drive_boost   <= RST_BYTE[UP_BOOST_MSB:0];
         high_ports_drive_boost <= RST_BYTE[HI_BOOST_MSB:0];
         low_ports_drive_boost  <= RST_BYTE;
         line_pair_swap         <= RST_BYTE;
         cfg_rdata              <= READ_ZERO;
      end
      else
      begin
         if (wr_up)
            upstream_drive_boost <= cfg_wdata[UP_BOOST_MSB:0];
         if (wr_hi)
            high_ports_drive_boost <= cfg_wdata[HI_BOOST_MSB:0];
         if (wr_lo)
            low_ports_drive_boost <= cfg_wdata;
         if (wr_swap)
            line_pair_swap <= cfg_wdata;
         if (cfg_rd)
            cfg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Field routing
   // ----------------------------------------
   assign upstream_boost_level = upstream_drive_boost;
   assign port7_boost_level    = high_ports_drive_boost[P7_LSB +: BOOST_W];
   assign port6_boost_level    = high_ports_drive_boost[P6_LSB +: BOOST_W];
   assign port5_boost_level    = high_ports_drive_boost[P5_LSB +: BOOST_W];
   assign port4_boost_level    = low_ports_drive_boost[P4_LSB +: BOOST_W];
   assign port3_boost_level    = low_ports_drive_boost[P3_LSB +: BOOST_W];
   assign port2_boost_level    = low_ports_drive_boost[P2_LSB +: BOOST_W];
   assign port1_boost_level    = low_ports_drive_boost[P1_LSB +: BOOST_W];
   assign line_pair_swap_bits  = line_pair_swap;

   // Index 0 is upstream, index n is downstream port n
   assign boost_vec = {high_ports_drive_boost, low_ports_drive_boost, upstream_drive_boost};

   // ----------------------------------------
   // Per-port decode and pin swap
   // ----------------------------------------
   // One cycle of latency on the pin path is the price of flopped outputs
   for (genvar p = 0; p < NUM_PORTS; p++)
   begin : g_port
      wire pdb_boost_t code = pdb_boost_t'(boost_vec[p*BOOST_W +: BOOST_W]);
      wire logic       sw   = line_pair_swap[p];

      always_ff @(posedge clk_sys or negedge rst_b)
      begin
         if (!rst_b)
         begin
            boost_step_low[p]    <= 1'b0;
            boost_step_med[p]    <= 1'b0;
            boost_step_high[p]   <= 1'b0;
            positive_line_pin[p] <= 1'b0;
            negative_line_pin[p] <= 1'b0;
            rx_dplus[p]          <= 1'b0;
            rx_dminus[p]         <= 1'b0;
         end
         else
         begin
            boost_step_low[p]    <= (code == PDB_BOOST_LOW);
            boost_step_med[p]    <= (code == PDB_BOOST_MED);
            boost_step_high[p]   <= (code == PDB_BOOST_HIGH);
            positive_line_pin[p] <= sw ? tx_dminus[p] : tx_dplus[p];
            negative_line_pin[p] <= sw ? tx_dplus[p] : tx_dminus[p];
            rx_dplus[p]          <= sw ? negative_line_in[p] : positive_line_in[p];
            rx_dminus[p]         <= sw ? positive_line_in[p] : negative_line_in[p];
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_wr_up;
      wr_up;
   endsequence

   sequence s_wr_hi;
      wr_hi;
   endsequence

   sequence s_wr_lo;
      wr_lo;
   endsequence

   // Decoded steps trail the register by one more edge
   sequence s_lo_settled;
      s_wr_lo ##1 1'b1;
   endsequence

   AST_UP_LEVEL: assert property (s_wr_up |=> upstream_boost_level == $past(cfg_wdata[1:0]))
      else $error("upstream boost level not taken from written bits");

   AST_DECODE: assert property (s_wr_up ##1 1'b1 |=>
      boost_step_high[UP_PORT] == ($past(cfg_wdata[1:0], 2) == 2'h3) &&
      boost_step_low[UP_PORT] == ($past(cfg_wdata[1:0], 2) == 2'h1))
      else $error("boost code decode wrong");

   AST_ONEHOT: assert property ($onehot0({boost_step_low[7], boost_step_med[7], boost_step_high[7]}))
      else $error("more than one boost step active");

   AST_HI_ROUTE: assert property (s_wr_hi |=> port7_boost_level == $past(cfg_wdata[5:4]) &&
      port5_boost_level == $past(cfg_wdata[1:0]))
      else $error("high port boost routed wrong");

   AST_LO_ROUTE: assert property (s_wr_lo |=> port4_boost_level == $past(cfg_wdata[7:6]) &&
      port1_boost_level == $past(cfg_wdata[1:0]))
      else $error("low port boost routed wrong");

   AST_SWAP_PIN: assert property (##1 $stable(line_pair_swap) |->
      positive_line_pin == (($past(line_pair_swap) & $past(tx_dminus)) |
                            (~$past(line_pair_swap) & $past(tx_dplus))))
      else $error("positive line pin mapping wrong");

   AST_SWAP_UP: assert property (cfg_wr && cfg_addr == ADDR_SWAP ##1 1'b1 |=>
      negative_line_pin[UP_PORT] == ($past(cfg_wdata[0], 2) ? $past(tx_dplus[0]) : $past(tx_dminus[0])))
      else $error("upstream swap not controlled by bit 0");

   AST_RSVD_UP: assert property (cfg_rd && cfg_addr == ADDR_UP_BOOST |=> cfg_rdata[7:2] == 6'h00)
      else $error("upstream reserved bits read nonzero");

   AST_RSVD_HI: assert property (cfg_rd && cfg_addr == ADDR_HI_BOOST |=> cfg_rdata[7:6] == 2'h0)
      else $error("high port reserved bits read nonzero");

   AST_DECODE_MED: assert property (s_lo_settled |=>
      boost_step_med[1] == ($past(cfg_wdata[1:0], 2) == 2'h2))
      else $error("medium boost step decode wrong");

   AST_HI_MID: assert property (s_wr_hi |=> port6_boost_level == $past(cfg_wdata[3:2]))
      else $error("port 6 boost routed wrong");

   AST_LO_MID: assert property (s_wr_lo |=> port3_boost_level == $past(cfg_wdata[5:4]) &&
      port2_boost_level == $past(cfg_wdata[3:2]))
      else $error("ports 3 and 2 boost routed wrong");

   AST_SWAP_RX: assert property (##1 $stable(line_pair_swap) |->
      rx_dplus == (($past(line_pair_swap) & $past(negative_line_in)) |
                   (~$past(line_pair_swap) & $past(positive_line_in))))
      else $error("receive line mapping wrong");

endmodule : pdb_regs

// *** verif/pdb_cfg_host.sv ***
// Configuration writer model driving the byte register port
`timescale 1ns/1ps

module pdb_cfg_host
(
   input  wire logic       clk_sys,
   input  wire logic [7:0] cfg_rdata,
   output logic      [7:0] cfg_addr,
   output logic      [7:0] cfg_wdata,
   output logic            cfg_wr,
   output logic            cfg_rd
);
   // Every boost field stays zero until a test asks otherwise
   initial
   begin
      cfg_addr  = 8'h00;
      cfg_wdata = 8'h00;
      cfg_wr    = 1'b0;
      cfg_rd    = 1'b0;
   end

   // One byte per call; idle address and data are inverted, not left stale
   task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_sys);
      #1;
      cfg_addr  = a;
      cfg_wdata = d;
      cfg_wr    = ~rd;
      cfg_rd    = rd;
      @(posedge clk_sys);
      #1;
      q         = cfg_rdata;
      cfg_wr    = 1'b0;
      cfg_rd    = 1'b0;
      cfg_addr  = ~a;
      cfg_wdata = ~d;
   endtask : xfer
endmodule : pdb_cfg_host

// *** verif/test_port_drive_boost_and_swap_cfg.sv ***
// Self-checking bench for the boost and line swap register bank
`timescale 1ns/1ps

module test_port_drive_boost_and_swap_cfg;
   import pdb_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst_b;
   logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
   logic        cfg_wr, cfg_rd;
   logic [15:0] lvl;
   logic [7:0]  st_lo, st_md, st_hi, swp, tx_p, tx_m, pin_p, pin_m, in_p, in_m, rx_p, rx_m;
   int          mismatches = 0;
   int          num_checks = 0;

   pdb_cfg_host i_pdb_cfg_host (.clk_sys(clk_sys), .cfg_rdata(cfg_rdata), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd));

   pdb_regs i_pdb_regs (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .upstream_boost_level(lvl[1:0]),
      .port1_boost_level(lvl[3:2]), .port2_boost_level(lvl[5:4]), .port3_boost_level(lvl[7:6]),
      .port4_boost_level(lvl[9:8]), .port5_boost_level(lvl[11:10]), .port6_boost_level(lvl[13:12]),
      .port7_boost_level(lvl[15:14]), .boost_step_low(st_lo), .boost_step_med(st_md),
      .boost_step_high(st_hi), .line_pair_swap_bits(swp), .tx_dplus(tx_p), .tx_dminus(tx_m),
      .positive_line_pin(pin_p), .negative_line_pin(pin_m), .positive_line_in(in_p),
      .negative_line_in(in_m), .rx_dplus(rx_p), .rx_dminus(rx_m));

   always #25 clk_sys = ~clk_sys;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic conclude();
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      logic [7:0] q;
      chk("levels_reset", 16'h0000, lvl);
      chk("swap_reset", 8'h00, swp);
      i_pdb_cfg_host.xfer(1'b1, ADDR_LO_BOOST, 8'h00, q);
      chk("read_lo_reset", 8'h00, q);
   endtask : t_reset

   // A mid-run reset must clear configured state, not only the power-up state
   task automatic t_rerun_reset();
      @(posedge clk_sys);
      #1;
      rst_b = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("steps_in_reset", 8'h00, st_lo | st_md | st_hi);
      chk("pins_in_reset", 8'h00, pin_p | pin_m);
      rst_b = 1'b1;
      t_reset();
   endtask : t_rerun_reset

   // Each port sees all four codes; reserved bits written as ones
   task automatic t_boost();
      logic [7:0]  q, lo, md, hi;
      logic [15:0] e;
      for (int c = 0; c < 4; c++)
      begin
         i_pdb_cfg_host.xfer(1'b0, ADDR_UP_BOOST, 8'hFC | 8'(c), q);
         i_pdb_cfg_host.xfer(1'b0, ADDR_HI_BOOST, {2'h3, 2'(c + 2), 2'(c + 1), 2'(c)}, q);
         i_pdb_cfg_host.xfer(1'b0, ADDR_LO_BOOST, {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)}, q);
         e = {2'(c + 2), 2'(c + 1), 2'(c), 2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c), 2'(c)};
         chk("levels", e, lvl);
         @(posedge clk_sys);
         #1;
         for (int i = 0; i < 8; i++)
         begin
            lo[i] = (e[2*i +: 2] == 2'h1);
            md[i] = (e[2*i +: 2] == 2'h2);
            hi[i] = (e[2*i +: 2] == 2'h3);
         end
         chk("step_low", lo, st_lo);
         chk("step_med", md, st_md);
         chk("step_high", hi, st_hi);
         i_pdb_cfg_host.xfer(1'b1, ADDR_UP_BOOST, 8'h00, q);
         chk("read_up", {6'h00, e[1:0]}, q);
         i_pdb_cfg_host.xfer(1'b1, ADDR_HI_BOOST, 8'h00, q);
         chk("read_hi", {2'h0, e[15:10]}, q);
         i_pdb_cfg_host.xfer(1'b1, ADDR_LO_BOOST, 8'h00, q);
         chk("read_lo", e[9:2], q);
      end
   endtask : t_boost

   task automatic t_swap();
      logic [7:0] q, s;
      i_pdb_cfg_host.xfer(1'b0, 8'hF9, 8'hFF, q);
      i_pdb_cfg_host.xfer(1'b1, 8'hF9, 8'h00, q);
      chk("read_unmapped", 8'h00, q);
      for (int k = 0; k < 2; k++)
      begin
         s = k ? 8'hA5 : 8'h00;
         i_pdb_cfg_host.xfer(1'b0, ADDR_SWAP, s, q);
         i_pdb_cfg_host.xfer(1'b1, ADDR_SWAP, 8'h00, q);
         chk("read_swap", s, q);
         chk("swap_bits", s, swp);
         // Every bit differs between the pair, so each swap bit is visible
         tx_p = 8'h0F;
         tx_m = 8'hF0;
         in_p = 8'h3C;
         in_m = 8'hC3;
         repeat (2) @(posedge clk_sys);
         #1;
         chk("pin_pos", (tx_p & ~s) | (tx_m & s), pin_p);
         chk("pin_neg", (tx_m & ~s) | (tx_p & s), pin_m);
         chk("rx_pos", (in_p & ~s) | (in_m & s), rx_p);
         chk("rx_neg", (in_m & ~s) | (in_p & s), rx_m);
      end
   endtask : t_swap

   initial
   begin
      rst_b = 1'b0;
      tx_p  = 8'h00;
      tx_m  = 8'h00;
      in_p  = 8'h00;
      in_m  = 8'h00;
      repeat (5) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      t_reset();
      t_boost();
      t_swap();
      t_rerun_reset();
      conclude();
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      #100000;
      mismatches++;
      conclude();
   end
endmodule : test_port_drive_boost_and_swap_cfg
